// ==== hw/rtc_calendar_alarm_regs.sv ====
// calendar clock core: counters, alarm, register port and pins
`timescale 1ns/1ps
module rtc_calendar_alarm_regs
  import rtc_pkg::*;
#(
  parameter int unsigned OSC_FAIL_CYCLES = OSC_FAIL_CYC
)
(
  input  wire logic       sys_clk,          // system clock, 250 MHz
  input  wire logic       rst,              // sync reset, active high
  input  wire logic       osc_clk,          // oscillator clock
  input  wire logic [7:0] reg_addr,         // register address
  input  wire logic       reg_wr,           // write strobe
  input  wire logic       reg_rd,           // read strobe
  input  wire logic [7:0] reg_wdata,        // write data
  output logic      [7:0] reg_rdata,        // read data
  output logic            reg_ack,          // access answered
  output logic            int_pin_o,        // interrupt pin level
  output logic            int_pin_oe,       // interrupt pin drive
  output logic            square_wave_pin_o,  // square pin level
  output logic            square_wave_pin_oe  // square pin drive
);
  typedef struct packed {
    logic              osc_stop_flag;
    logic [6:0]        sec;
    logic [6:0]        min;
    logic [5:0]        hour;
    logic [5:0]        date;
    logic [2:0]        wday;
    logic [4:0]        month;
    logic [7:0]        year;
    logic [7:0]        al_min;
    logic [6:0]        al_hour;
    logic [6:0]        al_date;
    logic [3:0]        al_wday;
    logic              alarm_irq_enable;
    logic              alarm_flag;
    logic              square_out_enable;
    logic [1:0]        square_rate_select;
    logic              match_prev;
    logic              sec_prev;
    logic              beat_prev;
    logic [WDOG_W-1:0] wdog;
    logic              div_rst;
    logic [WDOG_W+1:0] rst_cnt;
    logic [7:0]        rdata;
    logic              ack;
  } state_s;

  state_s     s_q;
  state_s     s_d;
  logic       sec_toggle;
  logic       beat_toggle;
  logic       wave;
  logic [1:0] osc_s;
  logic       tick;
  logic       beat;
  logic       osc_fail;
  logic       match;
  logic       alarm_rise;
  logic       in_map;
  logic       wr_hit;

  // a short system reset is stretched so the oscillator side sees it
  localparam logic [WDOG_W+1:0] RST_LAST =
    (WDOG_W+2)'(OSC_RST_SPANS * OSC_FAIL_CYCLES - 1);

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
    begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end
    else
    begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // multiple of four in BCD: even tens with 0/4/8, odd tens with 2/6
  function automatic logic is_leap(input logic [7:0] y);
    if (!y[4])
    begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    else
    begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
  endfunction

  function automatic logic [5:0] last_date(input logic [4:0] m,
                                           input logic       leap);
    case (m)
      5'h02:   last_date = leap ? 6'h29 : 6'h28;
      5'h04,
      5'h06,
      5'h09,
      5'h11:   last_date = 6'h30;
      default: last_date = 6'h31;
    endcase
  endfunction

  rtc_osc_divider u_div (
    .osc_clk     (osc_clk),
    .rst         (s_q.div_rst),
    .rate_sel    (s_q.square_rate_select),
    .sec_toggle  (sec_toggle),
    .beat_toggle (beat_toggle),
    .wave        (wave)
  );

  rtc_sync3 #(.W(2)) u_osc_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   ({sec_toggle, beat_toggle}),
    .q   (osc_s)
  );

  // no tick while the divider restarts, its toggle may jump back
  assign tick     = osc_s[1] != s_q.sec_prev && !s_q.div_rst;
  assign beat     = osc_s[0] != s_q.beat_prev;
  assign osc_fail = s_q.wdog == WDOG_W'(OSC_FAIL_CYCLES - 1);
  assign in_map   = reg_addr <= ADDR_LAST;
  assign wr_hit   = reg_wr && in_map;

  // all enabled fields equal, at least one field enabled
  always_comb
  begin
    match = (s_q.al_min[MATCH_EN_N_BIT] ||
             s_q.al_min[6:0] == s_q.min) &&
            (s_q.al_hour[6] || s_q.al_hour[5:0] == s_q.hour) &&
            (s_q.al_date[6] || s_q.al_date[5:0] == s_q.date) &&
            (s_q.al_wday[3] || s_q.al_wday[2:0] == s_q.wday) &&
            !(s_q.al_min[MATCH_EN_N_BIT] && s_q.al_hour[6] &&
              s_q.al_date[6] && s_q.al_wday[3]);
  end

  assign alarm_rise = match && !s_q.match_prev;

  always_comb
  begin
    s_d            = s_q;
    s_d.sec_prev   = osc_s[1];
    s_d.beat_prev  = osc_s[0];
    s_d.match_prev = match;
    s_d.ack        = 1'b0;
    s_d.rdata      = 8'h00;
    // oscillator watchdog
    if (beat)
    begin
      s_d.wdog = '0;
    end
    else if (!osc_fail)
    begin
      s_d.wdog = s_q.wdog + WDOG_W'(1);
    end
    // hold divider reset until several oscillator edges have passed
    if (s_q.div_rst)
    begin
      s_d.rst_cnt = s_q.rst_cnt + (WDOG_W+2)'(1);
      if (s_q.rst_cnt == RST_LAST)
      begin
        s_d.div_rst = 1'b0;
      end
    end
    // time chain
    if (tick)
    begin
      if (s_q.sec == SEC_MAX)
      begin
        s_d.sec = 7'h00;
        if (s_q.min == MIN_MAX)
        begin
          s_d.min = 7'h00;
          if (s_q.hour == HOUR_MAX)
          begin
            s_d.hour = 6'h00;
            s_d.wday = (s_q.wday == WDAY_MAX) ? 3'h0
                                              : s_q.wday + 3'h1;
            if (s_q.date == last_date(s_q.month, is_leap(s_q.year)))
            begin
              s_d.date = DATE_MIN;
              if (s_q.month == MONTH_MAX)
              begin
                s_d.month = MONTH_MIN;
                s_d.year  = (s_q.year == YEAR_MAX) ? 8'h00
                                                   : bcd_inc(s_q.year);
              end
              else
              begin
                s_d.month = 5'(bcd_inc({3'h0, s_q.month}));
              end
            end
            else
            begin
              s_d.date = 6'(bcd_inc({2'h0, s_q.date}));
            end
          end
          else
          begin
            s_d.hour = 6'(bcd_inc({2'h0, s_q.hour}));
          end
        end
        else
        begin
          s_d.min = 7'(bcd_inc({1'b0, s_q.min}));
        end
      end
      else
      begin
        s_d.sec = 7'(bcd_inc({1'b0, s_q.sec}));
      end
    end
    // register writes override the tick
    if (wr_hit)
    begin
      case (reg_addr)
        ADDR_ALARM_CS:
        begin
          s_d.alarm_irq_enable = reg_wdata[ALARM_IRQ_BIT];
          if (!reg_wdata[ALARM_FLAG_BIT])
          begin
            s_d.alarm_flag = 1'b0;
          end
        end
        ADDR_SECONDS:
        begin
          s_d.sec = reg_wdata[6:0];
          if (!reg_wdata[OSC_STOP_BIT])
          begin
            s_d.osc_stop_flag = 1'b0;
          end
        end
        ADDR_MINUTES:  s_d.min     = reg_wdata[6:0];
        ADDR_HOURS:    s_d.hour    = reg_wdata[5:0];
        ADDR_DATE:     s_d.date    = reg_wdata[5:0];
        ADDR_WEEKDAY:  s_d.wday    = reg_wdata[2:0];
        ADDR_MONTH:    s_d.month   = reg_wdata[4:0];
        ADDR_YEAR:     s_d.year    = reg_wdata;
        ADDR_AL_MIN:   s_d.al_min  = reg_wdata;
        ADDR_AL_HOUR:  s_d.al_hour = {reg_wdata[7], reg_wdata[5:0]};
        ADDR_AL_DATE:  s_d.al_date = {reg_wdata[7], reg_wdata[5:0]};
        ADDR_AL_WDAY:  s_d.al_wday = {reg_wdata[7], reg_wdata[2:0]};
        ADDR_SQW_CTRL:
        begin
          s_d.square_out_enable  = reg_wdata[SQ_ENABLE_BIT];
          s_d.square_rate_select = reg_wdata[1:0];
        end
        default: s_d.ack = 1'b1;
      endcase
      s_d.ack = 1'b1;
    end
    // hardware sets win over software clears
    if (alarm_rise)
    begin
      s_d.alarm_flag = 1'b1;
    end
    if (osc_fail)
    begin
      s_d.osc_stop_flag = 1'b1;
    end
    // read path; unused bits read zero
    if (reg_rd && in_map)
    begin
      s_d.ack = 1'b1;
      case (reg_addr)
        ADDR_ALARM_CS:
          s_d.rdata = {4'h0, s_q.alarm_flag, 1'b0,
                       s_q.alarm_irq_enable, 1'b0};
        ADDR_SECONDS:  s_d.rdata = {s_q.osc_stop_flag, s_q.sec};
        ADDR_MINUTES:  s_d.rdata = {1'b0, s_q.min};
        ADDR_HOURS:    s_d.rdata = {2'h0, s_q.hour};
        ADDR_DATE:     s_d.rdata = {2'h0, s_q.date};
        ADDR_WEEKDAY:  s_d.rdata = {5'h00, s_q.wday};
        ADDR_MONTH:    s_d.rdata = {3'h0, s_q.month};
        ADDR_YEAR:     s_d.rdata = s_q.year;
        ADDR_AL_MIN:   s_d.rdata = s_q.al_min;
        ADDR_AL_HOUR:
          s_d.rdata = {s_q.al_hour[6], 1'b0, s_q.al_hour[5:0]};
        ADDR_AL_DATE:
          s_d.rdata = {s_q.al_date[6], 1'b0, s_q.al_date[5:0]};
        ADDR_AL_WDAY:
          s_d.rdata = {s_q.al_wday[3], 4'h0, s_q.al_wday[2:0]};
        ADDR_SQW_CTRL:
          s_d.rdata = {s_q.square_out_enable, 5'h00,
                       s_q.square_rate_select};
        default:       s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q                    <= '0;
      s_q.osc_stop_flag      <= OSC_STOP_RST;
      s_q.div_rst            <= 1'b1;
      s_q.date               <= DATE_MIN;
      s_q.month              <= MONTH_MIN;
      s_q.al_min[7]          <= MATCH_EN_N_RST;
      s_q.al_hour[6]         <= MATCH_EN_N_RST;
      s_q.al_date[6]         <= MATCH_EN_N_RST;
      s_q.al_wday[3]         <= MATCH_EN_N_RST;
      s_q.alarm_irq_enable   <= ALARM_IRQ_RST;
      s_q.alarm_flag         <= ALARM_FLAG_RST;
      s_q.square_out_enable  <= SQ_ENABLE_RST;
      s_q.square_rate_select <= SQ_RATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata          = s_q.rdata;
  assign reg_ack            = s_q.ack;
  assign int_pin_o          = 1'b0;
  assign int_pin_oe         = s_q.alarm_irq_enable && s_q.alarm_flag;
  assign square_wave_pin_o  = wave && s_q.square_out_enable;
  assign square_wave_pin_oe = s_q.square_out_enable;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence sec_wrap_s;
    tick && s_q.sec == SEC_MAX && !wr_hit;
  endsequence

  sequence min_wrap_s;
    sec_wrap_s ##0 s_q.min == MIN_MAX;
  endsequence

  sequence hour_wrap_s;
    min_wrap_s ##0 s_q.hour == HOUR_MAX;
  endsequence

  addr_refuse_a: assert property (
    (reg_rd || reg_wr) && !in_map |=> !reg_ack)
    else $error("access above last address was answered");

  irq_en_write_a: assert property (
    wr_hit && reg_addr == ADDR_ALARM_CS |=>
    s_q.alarm_irq_enable == $past(reg_wdata[ALARM_IRQ_BIT]))
    else $error("interrupt enable did not take written value");

  flag_clear_a: assert property (
    wr_hit && reg_addr == ADDR_ALARM_CS &&
    !reg_wdata[ALARM_FLAG_BIT] && !alarm_rise |=> !s_q.alarm_flag)
    else $error("alarm flag not cleared by zero write");

  flag_hold_a: assert property (
    s_q.alarm_flag && !(wr_hit && reg_addr == ADDR_ALARM_CS &&
    !reg_wdata[ALARM_FLAG_BIT]) |=> s_q.alarm_flag)
    else $error("alarm flag dropped without a clear");

  alarm_set_a: assert property (
    alarm_rise |=> s_q.alarm_flag)
    else $error("alarm flag not set on new match");

  int_pin_a: assert property (
    s_q.alarm_flag && s_q.alarm_irq_enable |-> int_pin_oe && !int_pin_o)
    else $error("interrupt pin not driven for enabled alarm");

  sec_wrap_a: assert property (
    sec_wrap_s ##0 s_q.min != MIN_MAX |=>
    s_q.sec == 7'h00 && s_q.min != $past(s_q.min))
    else $error("seconds wrap did not step minutes");

  hour_step_a: assert property (
    min_wrap_s ##0 s_q.hour != HOUR_MAX |=>
    s_q.min == 7'h00 && s_q.hour != $past(s_q.hour))
    else $error("minutes wrap did not step hours");

  day_step_a: assert property (
    hour_wrap_s |=> s_q.hour == 6'h00 && s_q.wday != $past(s_q.wday))
    else $error("hours wrap did not step weekday");

  wday_wrap_a: assert property (
    hour_wrap_s ##0 s_q.wday == WDAY_MAX |=> s_q.wday == 3'h0)
    else $error("weekday did not return to zero");

  osc_stop_a: assert property (
    osc_fail |=> s_q.osc_stop_flag)
    else $error("oscillator failure did not set stop flag");

  sq_float_a: assert property (
    !s_q.square_out_enable |-> !square_wave_pin_oe && !square_wave_pin_o)
    else $error("square pin driven while disabled");
endmodule // rtc_calendar_alarm_regs

// ==== hw/rtc_osc_divider.sv ====
// oscillator-domain divider: second tick, heartbeat and square wave
`timescale 1ns/1ps
module rtc_osc_divider
  import rtc_pkg::*;
(
  input  wire logic       osc_clk,    // 32.768 kHz oscillator clock
  input  wire logic       rst,        // system reset, crossed here
  input  wire logic [1:0] rate_sel,   // square rate, system domain
  output logic            sec_toggle, // flips once per second
  output logic            beat_toggle,// flips every rising oscillator edge
  output logic            wave        // square wave before enable
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             sec_t;
    logic             beat_t;
  } state_s;

  state_s     s_q;
  state_s     s_d;
  logic [2:0] ctl_s;
  logic       osc_rst;
  logic [1:0] rate_s;

  rtc_sync3 #(.W(3)) u_ctl_sync (
    .clk (osc_clk),
    .rst (1'b0),
    .d   ({rst, rate_sel}),
    .q   (ctl_s)
  );

  assign osc_rst = ctl_s[2];
  assign rate_s  = ctl_s[1:0];

  always_comb
  begin
    s_d        = s_q;
    s_d.cnt    = s_q.cnt + 15'h0001;
    s_d.beat_t = ~s_q.beat_t;
    if (s_q.cnt == DIV_LAST)
    begin
      s_d.sec_t = ~s_q.sec_t;
    end
  end

  always_ff @(posedge osc_clk)
  begin
    if (osc_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // full rate passes the oscillator itself
  always_comb
  begin
    case (rate_s)
      RATE_32K: wave = osc_clk;
      RATE_1K:  wave = s_q.cnt[TAP_1K];
      RATE_32:  wave = s_q.cnt[TAP_32];
      RATE_1:   wave = s_q.cnt[TAP_1];
      default:  wave = 1'b0;
    endcase
  end

  assign sec_toggle  = s_q.sec_t;
  assign beat_toggle = s_q.beat_t;

  sec_tick_a: assert property (@(posedge osc_clk) disable iff (osc_rst)
    s_q.cnt == DIV_LAST |=> s_q.sec_t != $past(s_q.sec_t))
    else $error("second toggle missed at divider wrap");

  sec_quiet_a: assert property (@(posedge osc_clk) disable iff (osc_rst)
    s_q.cnt != DIV_LAST |=> $stable(s_q.sec_t))
    else $error("second toggle flipped off the wrap");
endmodule // rtc_osc_divider

// ==== hw/rtc_sync3.sv ====
// three-stage level synchroniser with agreement filter
`timescale 1ns/1ps
module rtc_sync3
  import rtc_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,  // destination clock
  input  wire logic         rst,  // sync reset, destination domain
  input  wire logic [W-1:0] d,    // asynchronous level in
  output logic      [W-1:0] q     // filtered level out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } state_s;

  state_s s_q;
  state_s s_d;

  always_comb
  begin
    s_d    = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3)
    begin
      s_d.q = s_q.s3;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign q = s_q.q;
endmodule // rtc_sync3

// ==== shared/rtc_pkg.sv ====
// constants, register map and field layout of the calendar clock core
// Functional notes
// - 8-bit register address; no answer to addresses above 0FH.
// - alarm interrupt enable in register 01 is read/write, resets disabled.
// - alarm flag reads its state; writing 0 clears, writing 1 keeps it.
// - alarm field takes part in matching only while its bit 7 is 0.
// - square enable 0 floats the square pin, 1 runs it; resets to 1.
// - rate select 00 32.768 kHz, 01 1.024 kHz, 10 32 Hz, 11 1 Hz.
// - seconds count BCD 00..59; the wrap steps minutes.
// - minutes count BCD 00..59; the wrap steps hours.
// - hours count BCD 00..23; the wrap steps date and weekday.
// - seconds bit 7 is the oscillator stop flag, reset value 1.
// - weekday counts 0..6 then back to 0.
// - date counts 1 to month length, leap February 29, then steps month.
// - month counts BCD 1..12; the wrap steps year.
// - year counts BCD 00..99; every multiple of four is leap.
// - software loads only legal values; illegal values need no handling.
// - unused bit positions and all of register 00 hold no storage.
// - oscillator failure sets the oscillator stop flag.
// - alarm flag sets on first full match, holds until cleared.
// - set alarm flag with interrupt enabled drives the interrupt pin.
package rtc_pkg;
  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h00;
  localparam logic [7:0] ADDR_ALARM_CS  = 8'h01;
  localparam logic [7:0] ADDR_SECONDS   = 8'h02;
  localparam logic [7:0] ADDR_MINUTES   = 8'h03;
  localparam logic [7:0] ADDR_HOURS     = 8'h04;
  localparam logic [7:0] ADDR_DATE      = 8'h05;
  localparam logic [7:0] ADDR_WEEKDAY   = 8'h06;
  localparam logic [7:0] ADDR_MONTH     = 8'h07;
  localparam logic [7:0] ADDR_YEAR      = 8'h08;
  localparam logic [7:0] ADDR_AL_MIN    = 8'h09;
  localparam logic [7:0] ADDR_AL_HOUR   = 8'h0A;
  localparam logic [7:0] ADDR_AL_DATE   = 8'h0B;
  localparam logic [7:0] ADDR_AL_WDAY   = 8'h0C;
  localparam logic [7:0] ADDR_SQW_CTRL  = 8'h0D;
  localparam logic [7:0] ADDR_LAST      = 8'h0F;
  // field positions
  localparam int ALARM_FLAG_BIT  = 3;
  localparam int ALARM_IRQ_BIT   = 1;
  localparam int OSC_STOP_BIT    = 7;
  localparam int MATCH_EN_N_BIT  = 7;
  localparam int SQ_ENABLE_BIT   = 7;
  // reset values
  localparam logic       OSC_STOP_RST   = 1'b1;
  localparam logic       ALARM_IRQ_RST  = 1'b0;
  localparam logic       ALARM_FLAG_RST = 1'b0;
  localparam logic       SQ_ENABLE_RST  = 1'b1;
  localparam logic [1:0] SQ_RATE_RST    = 2'h0;
  localparam logic       MATCH_EN_N_RST = 1'b1;
  // counter limits in BCD
  localparam logic [6:0] SEC_MAX   = 7'h59;
  localparam logic [6:0] MIN_MAX   = 7'h59;
  localparam logic [5:0] HOUR_MAX  = 6'h23;
  localparam logic [2:0] WDAY_MAX  = 3'h6;
  localparam logic [5:0] DATE_MIN  = 6'h01;
  localparam logic [4:0] MONTH_MIN = 5'h01;
  localparam logic [4:0] MONTH_MAX = 5'h12;
  localparam logic [7:0] YEAR_MAX  = 8'h99;
  // square rate selections and divider taps
  localparam logic [1:0] RATE_32K = 2'h0;
  localparam logic [1:0] RATE_1K  = 2'h1;
  localparam logic [1:0] RATE_32  = 2'h2;
  localparam logic [1:0] RATE_1   = 2'h3;
  localparam int DIV_W       = 15;
  localparam int TAP_1K      = 4;
  localparam int TAP_32      = 9;
  localparam int TAP_1       = 14;
  localparam logic [DIV_W-1:0] DIV_LAST = 15'h7FFF;
  // oscillator watchdog timing
  localparam int unsigned SYS_CLK_MHZ  = 250;
  localparam int unsigned OSC_FAIL_NS  = 100000;
  localparam int unsigned OSC_FAIL_CYC = OSC_FAIL_NS * SYS_CLK_MHZ / 1000;
  localparam int WDOG_W = 16;
  // divider reset lasts this many watchdog spans, several oscillator edges
  localparam int OSC_RST_SPANS = 8;
endpackage

// ==== verif/rtc_host_model.sv ====
// host side of the register port: one access per call
`timescale 1ns/1ps
module rtc_host_model
(
  input  wire logic       sys_clk,   // system clock
  input  wire logic [7:0] reg_rdata, // read data from core
  input  wire logic       reg_ack,   // access answered
  output logic      [7:0] reg_addr,  // register address
  output logic            reg_wr,    // write strobe
  output logic            reg_rd,    // read strobe
  output logic      [7:0] reg_wdata  // write data
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // only legal values reach the time counters; the alarm weekday is once loaded with 7
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic ok);
    int i;
    ok = 1'b0;
    q  = 8'h00;
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= wr;
    reg_rd    <= !wr;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    for (i = 0; i < 4 && !ok; i++)
    begin
      if (reg_ack === 1'b1)
      begin
        ok = 1'b1;
        q  = reg_rdata;
      end
      else
      begin
        @(posedge sys_clk);
        #1;
      end
    end
  endtask
endmodule // rtc_host_model

// ==== verif/tb.sv ====
// self-checking bench of the calendar clock core
`timescale 1ns/1ps
module tb;
  import rtc_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a, d, e;} row_s;
  logic       sys_clk, rst, osc_clk, osc_run;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic       reg_wr, reg_rd, reg_ack, ok;
  logic       int_o, int_oe, sq_o, sq_oe;
  int         bad_count, check_count, n, r;
  int         per [0:2] = '{20, 640, 20480};
  row_s       rows [0:15] = '{
    '{0, 8'h00, 8'h00, 8'h00},
    '{0, 8'h01, 8'h00, 8'h00},
    '{0, 8'h02, 8'h00, 8'h80},
    '{0, 8'h05, 8'h00, 8'h01},
    '{0, 8'h07, 8'h00, 8'h01},
    '{0, 8'h0A, 8'h00, 8'h80},
    '{0, 8'h0D, 8'h00, 8'h80},
    '{1, 8'h00, 8'hFF, 8'h00},
    '{1, 8'h02, 8'h45, 8'h45},
    '{1, 8'h03, 8'h59, 8'h59},
    '{1, 8'h04, 8'h23, 8'h23},
    '{1, 8'h06, 8'h06, 8'h06},
    '{1, 8'h08, 8'h99, 8'h99},
    '{1, 8'h0C, 8'hFF, 8'h87},
    '{1, 8'h01, 8'hFF, 8'h02},
    '{1, 8'h0D, 8'h83, 8'h83}};

  rtc_calendar_alarm_regs #(.OSC_FAIL_CYCLES(64)) dut (
    .sys_clk(sys_clk), .rst(rst), .osc_clk(osc_clk),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .int_pin_o(int_o), .int_pin_oe(int_oe),
    .square_wave_pin_o(sq_o), .square_wave_pin_oe(sq_oe));

  rtc_host_model host (
    .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // oscillator halts in place while osc_run is low
  initial
  begin
    osc_clk = 1'b0;
    #7;
    forever #40 if (osc_run) osc_clk = ~osc_clk;
  end

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", s, e, g);
      bad_count++;
    end
  endtask

  // write optional, then read back and compare
  task automatic wr_rd(input logic w, input logic [7:0] a, d, e);
    if (w)
    begin
      host.access(1'b1, a, d, q, ok);
      chk("write ack", 8'h01, {7'h00, ok});
    end
    host.access(1'b0, a, 8'h00, q, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk("read data", e, q);
  endtask

  task automatic hold_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // oscillator side restarts and its heartbeat returns
    repeat (1000) @(posedge sys_clk);
  endtask

  // cycles between two rising edges of the square pin
  task automatic measure(output int cnt);
    int i;
    cnt = 0;
    for (i = 0; i < 2; i++)
    begin
      while (sq_o !== 1'b0 && cnt < 50000)
      begin
        @(posedge sys_clk);
        cnt++;
      end
      while (sq_o !== 1'b1 && cnt < 50000)
      begin
        @(posedge sys_clk);
        cnt++;
      end
      if (i == 0)
        cnt = 0;
    end
    if (cnt >= 50000)
    begin
      bad_count++;
      stop_test();
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    bad_count = 0;
    check_count = 0;
    rst = 1'b1;
    osc_run = 1'b1;
    hold_reset();
    foreach (rows[i])
      wr_rd(rows[i].wr, rows[i].a, rows[i].d, rows[i].e);
    host.access(1'b0, 8'h10, 8'h00, q, ok);
    chk("unmapped read ack", 8'h00, {7'h00, ok});
    host.access(1'b1, 8'hFF, 8'h55, q, ok);
    chk("unmapped write ack", 8'h00, {7'h00, ok});
    // alarm minute field: disabled, then enabled on current minute
    wr_rd(1'b1, 8'h09, 8'hD9, 8'hD9);
    wr_rd(1'b0, 8'h01, 8'h00, 8'h02);
    wr_rd(1'b1, 8'h09, 8'h59, 8'h59);
    wr_rd(1'b0, 8'h01, 8'h00, 8'h0A);
    chk("irq pin drive", 8'h01, {7'h00, int_oe});
    wr_rd(1'b1, 8'h01, 8'h0A, 8'h0A);
    wr_rd(1'b1, 8'h01, 8'h02, 8'h02);
    chk("irq pin release", 8'h00, {7'h00, int_oe});
    for (r = 0; r < 3; r++)
    begin
      wr_rd(1'b1, 8'h0D, {6'h20, r[1:0]}, {6'h20, r[1:0]});
      // new rate needs a few oscillator edges to cross
      repeat (200) @(posedge sys_clk);
      measure(n);
      chk("square period ok", 8'h01, {7'h00, (n - per[r] <= 2) &&
                                     (per[r] - n <= 2)});
    end
    chk("square driven", 8'h01, {7'h00, sq_oe});
    wr_rd(1'b1, 8'h0D, 8'h01, 8'h01);
    chk("square floated", 8'h00, {7'h00, sq_oe});
    osc_run = 1'b0;
    repeat (200) @(posedge sys_clk);
    wr_rd(1'b0, 8'h02, 8'h00, 8'hC5);
    osc_run = 1'b1;
    repeat (100) @(posedge sys_clk);
    wr_rd(1'b1, 8'h02, 8'h12, 8'h12);
    hold_reset();
    wr_rd(1'b0, 8'h02, 8'h00, 8'h80);
    wr_rd(1'b0, 8'h0D, 8'h00, 8'h80);
    chk("irq after reset", 8'h00, {7'h00, int_oe});
    stop_test();
  end
endmodule // tb
